// *** core/aes_block_accelerator.sv ***
// Block cipher accelerator with an AHB-Lite register slave
// How it works
// - Encrypt and decrypt, 128 or 256-bit key
// - 128-bit key block done in 52 cycles
// - 256-bit key block done in 75 cycles
// - Data and key registers on AHB slave
`timescale 1ns/1ns
`include "aes_map.svh"
module aes_block_accelerator (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	aes_pkg::seq_e seq_reg;
	logic [31:0] key_reg [0:7];
	logic [31:0] data_reg [0:3];
	logic [255:0] kwin_reg;
	logic [127:0] work_reg;
	logic [3:0] kidx_reg;
	logic [6:0] cnt_reg;
	logic dec_reg;
	logic k256_reg;
	logic done_reg;
	logic wpend_reg;
	logic [5:0] waddr_reg;
	logic err_reg;

	logic addr_ok;
	logic take;
	logic wr_ctrl;
	logic wr_status;
	logic start;
	logic finish;
	logic [3:0] nrounds;
	logic [6:0] ncycles;
	logic [127:0] key_fwd;
	logic [127:0] key_bwd;
	logic [127:0] round_key;
	logic [127:0] round_out;
	logic round_last;

	// ----------------------------------------------------------------
	// Key schedule helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rcon(input logic [3:0] ri);
		if (ri == 4'h8) begin
			return 8'h1B;
		end else if (ri == 4'h9) begin
			return 8'h36;
		end
		return 8'h01 << ri[2:0];
	endfunction

	function automatic logic [31:0] ktrans(input logic [31:0] w, input logic rot, input logic [3:0] ri);
		logic [31:0] r;
		r = aes_pkg::subword(rot ? {w[23:0], w[31:24]} : w);
		if (rot) begin
			r[31:24] = r[31:24] ^ rcon(ri);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign take = hsel_i && hready_i && htrans_i[1];
	assign addr_ok = (haddr_i[7:2] <= `AES_IDX_STATUS)
		|| (haddr_i[7:2] >= `AES_IDX_KEY_FIRST && haddr_i[7:2] <= `AES_IDX_DATA_LAST);
	assign wr_ctrl = wpend_reg && (waddr_reg == `AES_IDX_CTRL);
	assign wr_status = wpend_reg && (waddr_reg == `AES_IDX_STATUS);
	assign start = wr_ctrl && hwdata_i[`AES_CTRL_START] && (seq_reg == aes_pkg::ST_IDLE);

	assign nrounds = k256_reg ? `AES_ROUNDS_K256 : `AES_ROUNDS_K128;
	assign ncycles = k256_reg ? `AES_CYCLES_K256 : `AES_CYCLES_K128;
	assign finish = (seq_reg == aes_pkg::ST_HOLD) && (cnt_reg == ncycles - 7'h01);

	// ----------------------------------------------------------------
	// Key schedule, forward and backward step
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] t;
		logic [31:0] lastw;
		logic [127:0] nw;
		logic [3:0] j;
		t = 32'h0;
		lastw = 32'h0;
		nw = 128'h0;
		j = 4'h0;
		// Forward step, 128 or 256-bit window
		lastw = k256_reg ? kwin_reg[31:0] : kwin_reg[159:128];
		t = ktrans(lastw, k256_reg ? ~kidx_reg[0] : 1'b1, k256_reg ? {1'b0, kidx_reg[3:1]} : kidx_reg);
		key_fwd[127:96] = kwin_reg[255:224] ^ t;
		key_fwd[95:64] = kwin_reg[223:192] ^ key_fwd[127:96];
		key_fwd[63:32] = kwin_reg[191:160] ^ key_fwd[95:64];
		key_fwd[31:0] = kwin_reg[159:128] ^ key_fwd[63:32];
		// Backward step undoes the last one
		j = kidx_reg - 4'h1;
		nw = k256_reg ? kwin_reg[127:0] : kwin_reg[255:128];
		lastw = k256_reg ? kwin_reg[159:128] : (nw[31:0] ^ nw[63:32]);
		t = ktrans(lastw, k256_reg ? ~j[0] : 1'b1, k256_reg ? {1'b0, j[3:1]} : j);
		key_bwd = {nw[127:96] ^ t, nw[95:64] ^ nw[127:96], nw[63:32] ^ nw[95:64], nw[31:0] ^ nw[63:32]};
	end

	assign round_key = dec_reg ? key_bwd : (k256_reg ? kwin_reg[127:0] : key_fwd);
	assign round_last = dec_reg ? (kidx_reg == 4'h1) : (kidx_reg == nrounds - 4'h1);

	aes_round u_round (
		.state_i(work_reg),
		.key_i(round_key),
		.decrypt_i(dec_reg),
		.last_i(round_last),
		.state_o(round_out)
	);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wpend_reg <= 1'b0;
			waddr_reg <= 6'h00;
			err_reg <= 1'b0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			hrdata_o <= `AES_WORD_RESET;
		end else if (err_reg) begin
			// Second cycle of an error answer
			err_reg <= 1'b0;
			hreadyout_o <= 1'b1;
		end else begin
			wpend_reg <= 1'b0;
			hresp_o <= 1'b0;
			hreadyout_o <= 1'b1;
			// Narrow writes and holes answer ERROR
			if (take && (!addr_ok || (hwrite_i && hsize_i != `AES_HSIZE_WORD))) begin
				err_reg <= 1'b1;
				hreadyout_o <= 1'b0;
				hresp_o <= 1'b1;
			end else if (take) begin
				wpend_reg <= hwrite_i;
				waddr_reg <= haddr_i[7:2];
				// Read data stands until the next read
				if (hwrite_i) begin
					hrdata_o <= hrdata_o;
				end else if (haddr_i[7:2] == `AES_IDX_CTRL) begin
					hrdata_o <= {29'h0, k256_reg, dec_reg, 1'b0};
				end else if (haddr_i[7:2] == `AES_IDX_STATUS) begin
					hrdata_o <= {30'h0, done_reg, seq_reg != aes_pkg::ST_IDLE};
				end else if (haddr_i[7:2] >= `AES_IDX_DATA_FIRST) begin
					hrdata_o <= data_reg[haddr_i[3:2]];
				end else begin
					hrdata_o <= key_reg[haddr_i[4:2] - 3'h4];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Key and data registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++) begin
				key_reg[i] <= `AES_WORD_RESET;
			end
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= `AES_WORD_RESET;
			end
		end else if (finish) begin
			for (int i = 0; i < 4; i++) begin
				data_reg[i] <= work_reg[127 - 32 * i -: 32];
			end
		end else if (wpend_reg && seq_reg == aes_pkg::ST_IDLE) begin
			if (waddr_reg >= `AES_IDX_DATA_FIRST) begin
				data_reg[waddr_reg[1:0]] <= hwdata_i;
			end else if (waddr_reg >= `AES_IDX_KEY_FIRST) begin
				key_reg[waddr_reg[2:0] - 3'h4] <= hwdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Done flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_reg <= 1'b0;
		end else if (finish) begin
			done_reg <= 1'b1;
		end else if (start || (wr_status && hwdata_i[`AES_STATUS_DONE])) begin
			done_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_reg <= aes_pkg::ST_IDLE;
			kwin_reg <= 256'h0;
			work_reg <= 128'h0;
			kidx_reg <= 4'h0;
			cnt_reg <= 7'h00;
			dec_reg <= 1'b0;
			k256_reg <= 1'b0;
		end else begin
			if (seq_reg != aes_pkg::ST_IDLE) begin
				cnt_reg <= cnt_reg + 7'h01;
			end
			case (seq_reg)
				aes_pkg::ST_IDLE: begin
					if (start) begin
						dec_reg <= hwdata_i[`AES_CTRL_DECRYPT];
						k256_reg <= hwdata_i[`AES_CTRL_KEY256];
						kwin_reg <= {key_reg[0], key_reg[1], key_reg[2], key_reg[3],
							key_reg[4], key_reg[5], key_reg[6], key_reg[7]};
						kidx_reg <= 4'h0;
						cnt_reg <= 7'h00;
						seq_reg <= hwdata_i[`AES_CTRL_DECRYPT] ? aes_pkg::ST_KEXP : aes_pkg::ST_LOAD;
					end
				end
				aes_pkg::ST_KEXP: begin
					kwin_reg <= k256_reg ? {kwin_reg[127:0], key_fwd} : {key_fwd, kwin_reg[127:0]};
					kidx_reg <= kidx_reg + 4'h1;
					if (kidx_reg == nrounds - 4'h1) begin
						seq_reg <= aes_pkg::ST_LOAD;
					end
				end
				aes_pkg::ST_LOAD: begin
					work_reg <= {data_reg[0], data_reg[1], data_reg[2], data_reg[3]} ^ kwin_reg[255:128];
					seq_reg <= aes_pkg::ST_RUN;
				end
				aes_pkg::ST_RUN: begin
					work_reg <= round_out;
					if (dec_reg) begin
						kwin_reg <= k256_reg ? {key_bwd, kwin_reg[255:128]} : {key_bwd, kwin_reg[127:0]};
						kidx_reg <= kidx_reg - 4'h1;
					end else begin
						kwin_reg <= k256_reg ? {kwin_reg[127:0], key_fwd} : {key_fwd, kwin_reg[127:0]};
						kidx_reg <= kidx_reg + 4'h1;
					end
					if (round_last) begin
						seq_reg <= aes_pkg::ST_HOLD;
					end
				end
				aes_pkg::ST_HOLD: begin
					// Release only at the fixed count
					if (finish) begin
						seq_reg <= aes_pkg::ST_IDLE;
					end
				end
				default: begin
					seq_reg <= aes_pkg::ST_IDLE;
				end
			endcase
		end
	end

endmodule // aes_block_accelerator

// *** core/aes_map.svh ***
// Register offsets, field positions, reset values and cycle counts of the cipher block
`ifndef AES_MAP_SVH
`define AES_MAP_SVH

// ----------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define AES_IDX_CTRL 6'h00
`define AES_IDX_STATUS 6'h01
`define AES_IDX_KEY_FIRST 6'h04
`define AES_IDX_KEY_LAST 6'h0B
`define AES_IDX_DATA_FIRST 6'h0C
`define AES_IDX_DATA_LAST 6'h0F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AES_CTRL_START 0
`define AES_CTRL_DECRYPT 1
`define AES_CTRL_KEY256 2
`define AES_STATUS_BUSY 0
`define AES_STATUS_DONE 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AES_CTRL_RESET 32'h0000_0000
`define AES_WORD_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Timing and round counts
// ----------------------------------------------------------------
`define AES_CYCLES_K128 7'h34
`define AES_CYCLES_K256 7'h4B
`define AES_ROUNDS_K128 4'hA
`define AES_ROUNDS_K256 4'hE
`define AES_HSIZE_WORD 3'h2

`endif

// *** core/aes_pkg.sv ***
// Types and field arithmetic shared by the cipher block files
package aes_pkg;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_KEXP = 3'h1,
		ST_LOAD = 3'h2,
		ST_RUN = 3'h3,
		ST_HOLD = 3'h4
	} seq_e;

	// ----------------------------------------------------------------
	// Finite field helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) begin
				p = p ^ x;
			end
			x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
		end
		return p;
	endfunction

	// Inverse as a to the power 254
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r;
		r = a;
		for (int i = 0; i < 6; i++) begin
			r = gmul(gmul(r, r), a);
		end
		return gmul(r, r);
	endfunction

	function automatic logic [7:0] sbox(input logic [7:0] x);
		logic [7:0] b;
		b = ginv(x);
		return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
	endfunction

	function automatic logic [7:0] isbox(input logic [7:0] y);
		return ginv({y[6:0], y[7]} ^ {y[4:0], y[7:5]} ^ {y[1:0], y[7:2]} ^ 8'h05);
	endfunction

	function automatic logic [31:0] subword(input logic [31:0] w);
		return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
	endfunction

	// Column mix, forward or inverse
	function automatic logic [31:0] mixcol(input logic [31:0] c, input logic inv);
		logic [7:0] s [0:3];
		logic [7:0] k [0:3];
		logic [31:0] o;
		for (int i = 0; i < 4; i++) begin
			s[i] = c[31 - 8 * i -: 8];
		end
		k[0] = inv ? 8'h0E : 8'h02;
		k[1] = inv ? 8'h0B : 8'h03;
		k[2] = inv ? 8'h0D : 8'h01;
		k[3] = inv ? 8'h09 : 8'h01;
		o = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			o[31 - 8 * i -: 8] = gmul(s[i], k[0]) ^ gmul(s[(i + 1) % 4], k[1])
				^ gmul(s[(i + 2) % 4], k[2]) ^ gmul(s[(i + 3) % 4], k[3]);
		end
		return o;
	endfunction

endpackage

// *** core/aes_round.sv ***
// One cipher round, forward or inverse, purely combinational
`timescale 1ns/1ns
module aes_round (
	// Round inputs
	input wire logic [127:0] state_i,
	input wire logic [127:0] key_i,
	input wire logic decrypt_i,
	input wire logic last_i,
	// Round result
	output logic [127:0] state_o
);

	always_comb begin
		logic [127:0] sh;
		logic [127:0] t;
		logic [127:0] mixed;
		int se;
		int sd;
		sh = 128'h0;
		t = 128'h0;
		mixed = 128'h0;
		se = 0;
		sd = 0;
		// Row shift and byte substitution
		for (int i = 0; i < 16; i++) begin
			se = (((i / 4) + (i % 4)) % 4) * 4 + (i % 4);
			sd = (((i / 4) - (i % 4) + 4) % 4) * 4 + (i % 4);
			sh[127 - 8 * i -: 8] = decrypt_i ? aes_pkg::isbox(state_i[127 - 8 * sd -: 8])
				: aes_pkg::sbox(state_i[127 - 8 * se -: 8]);
		end
		t = sh ^ key_i;
		// Column mix
		for (int c = 0; c < 4; c++) begin
			mixed[127 - 32 * c -: 32] = aes_pkg::mixcol(decrypt_i ? t[127 - 32 * c -: 32]
				: sh[127 - 32 * c -: 32], decrypt_i);
		end
		if (decrypt_i) begin
			state_o = last_i ? t : mixed;
		end else begin
			state_o = (last_i ? sh : mixed) ^ key_i;
		end
	end

endmodule // aes_round

// *** tb/aes_block_accelerator_asserts.sv ***
// Bus and timing checks on the cipher block ports
`timescale 1ns/1ns
module aes_block_checker (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take, mapped, st_rd, ct_rd, ctl_wr, st_wr, k2, dc, dn;
	logic [6:0] cnt;
	logic [6:0] lim;
	assign take = hsel_i && hready_i && htrans_i[1];
	assign mapped = haddr_i[7:2] < 6'h02 || (haddr_i[7:2] > 6'h03 && haddr_i[7:2] < 6'h10);
	assign st_rd = take && !hwrite_i && haddr_i[7:2] == 6'h01;
	assign ct_rd = take && !hwrite_i && haddr_i[7:2] == 6'h00;
	// One past the budget: flag seen by a read taken then
	assign lim = k2 ? 7'h4C : 7'h35;
	// ----
	// Operation tracker
	// ----
	always_ff @(posedge clk_i) begin
		ctl_wr <= !rst_i && take && hwrite_i && hsize_i == 3'h2 && haddr_i[7:2] == 6'h00;
		st_wr <= !rst_i && take && hwrite_i && hsize_i == 3'h2 && haddr_i[7:2] == 6'h01;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 7'h00;
			k2 <= 1'b0;
			dc <= 1'b0;
		end else if (ctl_wr && hwdata_i[0] && (cnt == 7'h00 || cnt == lim)) begin
			cnt <= 7'h01;
			k2 <= hwdata_i[2];
			dc <= hwdata_i[1];
		end else if (cnt != 7'h00 && cnt != lim) begin
			cnt <= cnt + 7'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (st_wr && hwdata_i[1]) || (ctl_wr && hwdata_i[0]))
			dn <= 1'b0;
		else if (cnt != 7'h00 && cnt + 7'h01 == lim)
			dn <= 1'b1;
	end
	sequence s_err;
		!hreadyout_o && hresp_o ##1 hreadyout_o && hresp_o;
	endsequence
	busy_read_a: assert property (st_rd && cnt != 7'h00 && cnt != lim |=> hrdata_o[1:0] == 2'h1)
		else $error("busy status wrong during operation");
	done_short_a: assert property (st_rd && dn && cnt == lim && !k2 |=> hrdata_o[1:0] == 2'h2)
		else $error("done missing after short key operation");
	done_long_a: assert property (st_rd && dn && cnt == lim && k2 |=> hrdata_o[1:0] == 2'h2)
		else $error("done missing after long key operation");
	ctrl_mode_a: assert property (ct_rd && cnt != 7'h00 |=> hrdata_o[2:0] == {k2, dc, 1'b0})
		else $error("mode bits not as started");
	word_write_a: assert property (take && hwrite_i && hsize_i == 3'h2 && mapped |=> hreadyout_o && !hresp_o)
		else $error("word write not answered okay");
	narrow_write_a: assert property (take && hwrite_i && hsize_i != 3'h2 |=> s_err)
		else $error("narrow write not refused");
	unmapped_err_a: assert property (take && !mapped |=> s_err)
		else $error("unmapped access not refused");
	err_length_a: assert property (!hreadyout_o |=> hreadyout_o && hresp_o ##1 !hresp_o)
		else $error("error response length wrong");
	rdata_hold_a: assert property (!(take && !hwrite_i) |=> $stable(hrdata_o))
		else $error("read data changed without read");
endmodule // aes_block_checker
bind aes_block_accelerator aes_block_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
	.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

// *** tb/ahb_master_model.sv ***
// AHB-Lite master model facing the cipher block
`timescale 1ns/1ns
module ahb_master_model (
	// Clock
	input wire logic clk_i,
	// Slave answer
	input wire logic [31:0] hrdata_i,
	input wire logic hreadyout_i,
	input wire logic hresp_i,
	// Master request
	output logic hsel_o,
	output logic [7:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [2:0] hsize_o,
	output logic [31:0] hwdata_o
);
	initial begin
		hsel_o = 1'b0;
		haddr_o = 8'h00;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0000_0000;
	end
	// One transfer, address then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] s, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(negedge clk_i);
		hsel_o = 1'b1;
		haddr_o = a;
		htrans_o = 2'h2;
		hwrite_o = w;
		hsize_o = s;
		do @(posedge clk_i); while (hreadyout_i !== 1'b1);
		@(negedge clk_i);
		hsel_o = 1'b0;
		htrans_o = 2'h0;
		haddr_o = ~a;
		hwdata_o = w ? d : ~hwdata_o;
		do @(posedge clk_i); while (hreadyout_i !== 1'b1);
		q = hrdata_i;
		e = hresp_i;
	endtask
endmodule // ahb_master_model

// *** tb/tb_top.sv ***
// Self-checking bench for the cipher block
`timescale 1ns/1ns
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic [7:0] haddr_i;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [31:0] hwdata_i, hrdata_o;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	localparam logic [255:0] K = 256'h000102030405060708090A0B0C0D0E0F101112131415161718191A1B1C1D1E1F;
	localparam logic [127:0] P = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] C1 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] C2 = 128'h8EA2B7CA516745BFEAFC49904B496089;
	always #10 clk_i = ~clk_i;
	aes_block_accelerator i_dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));
	ahb_master_model i_mst (.clk_i(clk_i), .hrdata_i(hrdata_o), .hreadyout_i(hreadyout_o), .hresp_i(hresp_o),
		.hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i),
		.hwdata_o(hwdata_i));
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
		checks_done++;
		if (y !== x) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, y);
		end
	endtask
	task automatic acc(input string n, input logic w, input logic [7:0] a, input logic [2:0] s,
		input logic [31:0] d, input logic [31:0] x, input logic ex);
		logic [31:0] q;
		logic e;
		i_mst.xfer(w, a, s, d, q, e);
		if (!w && !ex)
			chk(n, x, q);
		chk({n, " resp"}, {31'h0, ex}, {31'h0, e});
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		acc("status", 1'b0, 8'h04, 3'h2, 32'h0, 32'h0, 1'b0);
		acc("ctrl", 1'b0, 8'h00, 3'h2, 32'h0, 32'h0, 1'b0);
		acc("data", 1'b0, 8'h3C, 3'h2, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic t_op(input logic k2, input logic dec, input logic [127:0] di, input logic [127:0] dq,
		input int d);
		for (int i = 0; i < 8; i++)
			acc("key", 1'b1, 8'h10 + 8'(4 * i), 3'h2, K[255 - 32 * i -: 32], 32'h0, 1'b0);
		for (int i = 0; i < 4; i++)
			acc("din", 1'b1, 8'h30 + 8'(4 * i), 3'h2, di[127 - 32 * i -: 32], 32'h0, 1'b0);
		acc("start", 1'b1, 8'h00, 3'h2, {29'h0, k2, dec, 1'b1}, 32'h0, 1'b0);
		acc("busy write", 1'b1, 8'h30, 3'h2, 32'hFFFF_FFFF, 32'h0, 1'b0);
		repeat ((k2 ? 75 : 52) + d - 2) @(posedge clk_i);
		acc("timed status", 1'b0, 8'h04, 3'h2, 32'h0, d < 0 ? 32'h1 : 32'h2, 1'b0);
		acc("late status", 1'b0, 8'h04, 3'h2, 32'h0, 32'h2, 1'b0);
		acc("mode", 1'b0, 8'h00, 3'h2, 32'h0, {29'h0, k2, dec, 1'b0}, 1'b0);
		for (int i = 0; i < 4; i++)
			acc("result", 1'b0, 8'h30 + 8'(4 * i), 3'h2, 32'h0, dq[127 - 32 * i -: 32], 1'b0);
		acc("clear", 1'b1, 8'h04, 3'h2, 32'h2, 32'h0, 1'b0);
		acc("cleared", 1'b0, 8'h04, 3'h2, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic t_err();
		acc("word", 1'b1, 8'h30, 3'h2, 32'h1234_5678, 32'h0, 1'b0);
		acc("byte", 1'b1, 8'h30, 3'h0, 32'h0000_00AA, 32'h0, 1'b1);
		acc("half", 1'b1, 8'h30, 3'h1, 32'h0000_BBBB, 32'h0, 1'b1);
		acc("kept", 1'b0, 8'h30, 3'h2, 32'h0, 32'h1234_5678, 1'b0);
		acc("unmapped", 1'b0, 8'h40, 3'h2, 32'h0, 32'h0, 1'b1);
		acc("hole", 1'b1, 8'h08, 3'h2, 32'h0, 32'h0, 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		t_op(1'b0, 1'b0, P, C1, -1);
		t_op(1'b0, 1'b1, C1, P, 0);
		t_op(1'b1, 1'b0, P, C2, 0);
		t_op(1'b1, 1'b1, C2, P, -1);
		t_err();
		acc("restart", 1'b1, 8'h00, 3'h2, 32'h1, 32'h0, 1'b0);
		@(negedge clk_i);
		rst_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		t_reset();
		stop_test();
	end
endmodule // tb_top
